// ---- src/rmc_defines.vh ----
// rmc_defines.vh: constants for the real-time match counter block.
// assumes inclusion by bare name from the design files under src/.
`ifndef RMC_DEFINES_VH
`define RMC_DEFINES_VH

// ----------------------------------------------------------------
// counter geometry
// ----------------------------------------------------------------
`define RMC_CNT_W 40
`define RMC_DIV 128
`define RMC_DIV_W 7

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RMC_A_CTRL 8'h00
`define RMC_A_STAT 8'h04
`define RMC_A_MASK 8'h08
`define RMC_A_MLO 8'h0c
`define RMC_A_MHI 8'h10
`define RMC_A_CLO 8'h14
`define RMC_A_CHI 8'h18
`define RMC_A_ILO 8'h1c
`define RMC_A_IHI 8'h20

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define RMC_C_EN 0
`define RMC_C_RSTM 1
`define RMC_C_EXP 2
`define RMC_C_SEL 3
`define RMC_C_MODE_LO 4
`define RMC_C_MODE_HI 5
`define RMC_C_LOAD 8
`define RMC_CTRL_RST 32'h0000_0000
`define RMC_ST_MATCH 0
`define RMC_BAD_DATA 32'hdead_beef

`endif

// ---- src/rmc_prescale.v ----
// rmc_prescale.v: divide-by-N tick generator on the counter clock input.
// assumes the counter clock input is synchronous to REF_CLK.
`timescale 1ns/1ps

module rmc_prescale #(
   parameter DIV = 128,
   parameter W = 7
) (
   // clock and control
   input wire clk,
   input wire srst,
   input wire ce,
   input wire run,
   input wire clk_rise,
   // divided tick
   output reg tick
);
   // ----------------------------------------------------------------
   // divider count
   // ----------------------------------------------------------------
   reg [W-1:0] cnt_r; // edges seen so far
   // kept 32 bits wide and cut on purpose at the compare
   localparam [31:0] LAST = DIV - 1;

   // count input edges, pulse on the last one of each group
   always @(posedge clk) begin
      if (srst) begin
         cnt_r <= {W{1'b0}};
         tick <= 1'b0;
      end else if (ce) begin
         tick <= 1'b0;
         if (!run) begin
            cnt_r <= {W{1'b0}}; // restart phase when disabled
         end else if (clk_rise) begin
            if (cnt_r == LAST[W-1:0]) begin
               cnt_r <= {W{1'b0}};
               tick <= 1'b1;
            end else begin
               cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // rmc_prescale

// ---- src/rmc_top.v ----
// rmc_top.v: 40-bit real-time match counter with Avalon-MM registers.
// assumes COUNTER_CLOCK_IN comes from the oscillator clock output and is
// slow against REF_CLK; it is sampled and edge-detected, not used as a clock.
//
// Overview of operation
// - count only edges of oscillator clock input
// - drive oscillator select output to oscillator
// - drive two-bit oscillator gain mode output
// - match output rises when counter equals match while counting is enabled
// - second match output for supply monitor
// - second match output only when export enabled
// - count rate is oscillator clock over 128
// - counter and match value are 40 bits
// - optional reset to zero on match
// - counter starts from configurable initial value
`timescale 1ns/1ps
`include "rmc_defines.vh"

module rmc_top #(
   parameter CNT_W = `RMC_CNT_W,
   parameter DIV = `RMC_DIV,
   parameter DIV_W = `RMC_DIV_W
) (
   // clock, reset, enable
   input wire REF_CLK,
   input wire SRST,
   input wire CE,
   // oscillator link
   input wire COUNTER_CLOCK_IN,
   output reg OSCILLATOR_SELECT_OUT,
   output reg [1:0] OSCILLATOR_GAIN_MODE_OUT,
   // match outputs
   output reg MATCH_OUT,
   output reg SUPPLY_MONITOR_MATCH_OUT,
   // avalon-mm slave
   input wire [7:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output reg AVS_WAITREQUEST,
   // interrupt
   output reg IRQ
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [31:0] ctrl_r; // control bits
   reg [CNT_W-1:0] match_r; // programmed match value
   reg [CNT_W-1:0] init_r; // initial counter value
   reg [CNT_W-1:0] cnt_r; // running count
   reg stat_r; // sticky match event
   reg mask_r; // interrupt enable
   reg clk_prev_r; // last sample of counter clock
   reg ack_r; // answer phase of a bus access
   wire run = ctrl_r[`RMC_C_EN];
   wire clk_rise = COUNTER_CLOCK_IN & ~clk_prev_r;
   wire tick;
   wire eq = (cnt_r == match_r);
   reg eq_prev_r; // previous compare result, for edge
   wire match_ev = eq & ~eq_prev_r; // one event per arrival at match
   wire req = (AVS_READ | AVS_WRITE) & ~ack_r;
   wire wr = AVS_WRITE & req;
   wire clr_stat = wr & (AVS_ADDRESS == `RMC_A_STAT) & AVS_BYTEENABLE[0]
      & AVS_WRITEDATA[`RMC_ST_MATCH];
   reg [31:0] rd_nxt; // read mux result
   reg [63:0] wide_m; // zero-extended 40-bit helpers
   reg [63:0] wide_c;
   reg [63:0] wide_i;
   // upper match half merged in a full word, then cut to its real width
   wire [31:0] mhi_m = merge({{(64-CNT_W){1'b0}}, match_r[CNT_W-1:32]},
      AVS_WRITEDATA, AVS_BYTEENABLE);

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   rmc_prescale #(.DIV(DIV), .W(DIV_W)) u_div (
      .clk(REF_CLK),
      .srst(SRST),
      .ce(CE),
      .run(run),
      .clk_rise(clk_rise),
      .tick(tick)
   );

   // byte-lane merge for a write
   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0] be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge[i*8 +: 8] = din[i*8 +: 8];
            end
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // unmapped offsets answer with a fixed marker, writes there are dropped
   always @* begin
      wide_m = {{(64-CNT_W){1'b0}}, match_r};
      wide_c = {{(64-CNT_W){1'b0}}, cnt_r};
      wide_i = {{(64-CNT_W){1'b0}}, init_r};
      if (AVS_ADDRESS == `RMC_A_CTRL) begin
         rd_nxt = ctrl_r;
      end else if (AVS_ADDRESS == `RMC_A_STAT) begin
         rd_nxt = {31'h0, stat_r};
      end else if (AVS_ADDRESS == `RMC_A_MASK) begin
         rd_nxt = {31'h0, mask_r};
      end else if (AVS_ADDRESS == `RMC_A_MLO) begin
         rd_nxt = wide_m[31:0];
      end else if (AVS_ADDRESS == `RMC_A_MHI) begin
         rd_nxt = wide_m[63:32];
      end else if (AVS_ADDRESS == `RMC_A_CLO) begin
         rd_nxt = wide_c[31:0];
      end else if (AVS_ADDRESS == `RMC_A_CHI) begin
         rd_nxt = wide_c[63:32];
      end else if (AVS_ADDRESS == `RMC_A_ILO) begin
         rd_nxt = wide_i[31:0];
      end else if (AVS_ADDRESS == `RMC_A_IHI) begin
         rd_nxt = wide_i[63:32];
      end else begin
         rd_nxt = `RMC_BAD_DATA;
      end
   end

   // ----------------------------------------------------------------
   // bus slave: one wait cycle, then answer
   // ----------------------------------------------------------------
   // waitrequest sits high at idle and drops for one cycle per access
   always @(posedge REF_CLK) begin
      if (SRST) begin
         ack_r <= 1'b0;
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h0;
      end else if (CE) begin
         ack_r <= req;
         AVS_WAITREQUEST <= ~req;
         if (req & AVS_READ) begin
            AVS_READDATA <= rd_nxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // match is written in halves; the host keeps the counter off meanwhile
   // so a half-written value cannot fire a false match
   always @(posedge REF_CLK) begin
      if (SRST) begin
         ctrl_r <= `RMC_CTRL_RST;
         match_r <= {CNT_W{1'b1}};
         init_r <= {CNT_W{1'b0}};
         mask_r <= 1'b0;
      end else if (CE & wr) begin
         if (AVS_ADDRESS == `RMC_A_CTRL) begin
            ctrl_r <= merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE);
         end else if (AVS_ADDRESS == `RMC_A_MASK) begin
            if (AVS_BYTEENABLE[0]) begin
               mask_r <= AVS_WRITEDATA[0];
            end
         end else if (AVS_ADDRESS == `RMC_A_MLO) begin
            match_r[31:0] <= merge(match_r[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
         end else if (AVS_ADDRESS == `RMC_A_MHI) begin
            match_r[CNT_W-1:32] <= mhi_m[CNT_W-33:0];
         end else if (AVS_ADDRESS == `RMC_A_ILO) begin
            init_r[31:0] <= merge(init_r[31:0], AVS_WRITEDATA, AVS_BYTEENABLE);
         end else if (AVS_ADDRESS == `RMC_A_IHI) begin
            init_r[CNT_W-1:32] <= AVS_WRITEDATA[CNT_W-33:0];
         end
         if (AVS_ADDRESS != `RMC_A_CTRL) begin
            ctrl_r[`RMC_C_LOAD] <= 1'b0;
         end
      end else if (CE) begin
         ctrl_r[`RMC_C_LOAD] <= 1'b0; // load is self-clearing
      end
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always @(posedge REF_CLK) begin
      if (SRST) begin
         cnt_r <= {CNT_W{1'b0}};
         clk_prev_r <= 1'b0;
         eq_prev_r <= 1'b0;
      end else if (CE) begin
         clk_prev_r <= COUNTER_CLOCK_IN;
         eq_prev_r <= eq & run;
         if (ctrl_r[`RMC_C_LOAD]) begin
            cnt_r <= init_r;
         end else if (tick) begin
            if (eq & ctrl_r[`RMC_C_RSTM]) begin
               cnt_r <= {CNT_W{1'b0}};
            end else begin
               cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs, status and interrupt
   // ----------------------------------------------------------------
   // match outputs are levels while running and equal, the supply monitor one only with export set; all active high
   always @(posedge REF_CLK) begin
      if (SRST) begin
         MATCH_OUT <= 1'b0;
         SUPPLY_MONITOR_MATCH_OUT <= 1'b0;
         OSCILLATOR_SELECT_OUT <= 1'b0;
         OSCILLATOR_GAIN_MODE_OUT <= 2'h0;
         stat_r <= 1'b0;
         IRQ <= 1'b0;
      end else if (CE) begin
         MATCH_OUT <= eq & run;
         SUPPLY_MONITOR_MATCH_OUT <= eq & run & ctrl_r[`RMC_C_EXP];
         OSCILLATOR_SELECT_OUT <= ctrl_r[`RMC_C_SEL];
         OSCILLATOR_GAIN_MODE_OUT <= ctrl_r[`RMC_C_MODE_HI:`RMC_C_MODE_LO];
         // set wins over a clear in the same cycle
         stat_r <= (match_ev & run) | (stat_r & ~clr_stat);
         IRQ <= ((match_ev & run) | (stat_r & ~clr_stat)) & mask_r;
      end
   end
endmodule // rmc_top

// ---- test/rmc_osc_model.sv ----
// oscillator model: free-running clock for the counter, sees select/mode
// assumes a slow crystal against REF_CLK, synchronous to it
`timescale 1ns/1ps
module rmc_osc_model #(parameter HALF = 2) (
   // reference clock
   input wire logic clk,
   // control from the block
   input wire logic sel,
   input wire logic [1:0] mode,
   // oscillator output
   output logic osc_out
);
   int n = 0;
   logic sel_seen; // last select seen
   logic [1:0] mode_seen; // last gain mode seen
   initial osc_out = 1'b0;
   // a crystal runs free, frames or not
   always @(posedge clk) begin
      sel_seen <= sel;
      mode_seen <= mode;
      n <= (n == HALF - 1) ? 0 : n + 1;
      if (n == HALF - 1) osc_out <= ~osc_out;
   end
endmodule // rmc_osc_model

// ---- test/rmc_top_assertions.sv ----
// checker on the top ports of the match counter
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module rmc_top_assertions (
   input wire REF_CLK,
   input wire SRST,
   input wire CE,
   input wire COUNTER_CLOCK_IN,
   input wire OSCILLATOR_SELECT_OUT,
   input wire [1:0] OSCILLATOR_GAIN_MODE_OUT,
   input wire MATCH_OUT,
   input wire SUPPLY_MONITOR_MATCH_OUT,
   input wire [7:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire AVS_WAITREQUEST,
   input wire IRQ
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   logic [2:0] wr_hist; // recent control writes
   logic [7:0] act_hist; // recent oscillator edges or bus writes
   logic osc_d;
   wire req = (AVS_READ || AVS_WRITE) && CE;
   always @(posedge REF_CLK) begin
      osc_d <= COUNTER_CLOCK_IN;
      wr_hist <= {wr_hist[1:0], AVS_WRITE && AVS_ADDRESS == 8'h00 && !AVS_WAITREQUEST};
      act_hist <= {act_hist[6:0], (COUNTER_CLOCK_IN && !osc_d) || AVS_WRITE};
   end
   property p_sel; !$stable(OSCILLATOR_SELECT_OUT) |-> wr_hist != 3'h0; endproperty
   a_sel: assert property (p_sel) else $error("select moved without a write");
   property p_mode; !$stable(OSCILLATOR_GAIN_MODE_OUT) |-> wr_hist != 3'h0; endproperty
   a_mode: assert property (p_mode) else $error("mode moved without a write");
   property p_smon; SUPPLY_MONITOR_MATCH_OUT |-> MATCH_OUT; endproperty
   a_smon: assert property (p_smon) else $error("monitor match without match");
   property p_rise; $rose(MATCH_OUT) |-> act_hist != 8'h00; endproperty
   a_rise: assert property (p_rise) else $error("match rose without cause");
   property p_wait1; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
   a_wait1: assert property (p_wait1) else $error("answer longer than one cycle");
   property p_ans; req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
   a_ans: assert property (p_ans) else $error("request not answered next cycle");
   property p_nowait; !req && AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
   a_nowait: assert property (p_nowait) else $error("answer without request");
   property p_rst;
      $fell(SRST) |-> !MATCH_OUT && !IRQ && AVS_WAITREQUEST && !OSCILLATOR_SELECT_OUT;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not at reset level");
   c_match: cover property ($rose(MATCH_OUT));
   c_irq: cover property ($rose(IRQ));
   c_smon: cover property ($rose(SUPPLY_MONITOR_MATCH_OUT));
endmodule // rmc_top_assertions
bind rmc_top rmc_top_assertions i_rmc_top_assertions (.*);

// ---- test/test_rtc_match_counter.sv ----
// self-checking bench for the match counter over avalon-mm
// assumes a shortened divider so counts arrive within tens of cycles
`timescale 1ns/1ps
module test_rtc_match_counter;
   localparam int DIV = 4; // shortened prescale keeps the run short
   localparam int P = 4; // oscillator period in REF_CLK cycles
   logic REF_CLK = 0, SRST = 1, CE = 1, AVS_READ = 0, AVS_WRITE = 0, osc;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
   logic [3:0] AVS_BYTEENABLE = 4'hf;
   logic AVS_WAITREQUEST, OSCILLATOR_SELECT_OUT, MATCH_OUT, SUPPLY_MONITOR_MATCH_OUT, IRQ;
   logic [1:0] OSCILLATOR_GAIN_MODE_OUT;
   int miscompares = 0, checks_done = 0, n;
   rmc_top #(.DIV(DIV), .DIV_W(2)) i_rmc_top (.COUNTER_CLOCK_IN(osc), .*);
   rmc_osc_model #(.HALF(P / 2)) i_rmc_osc_model (.clk(REF_CLK),
      .sel(OSCILLATOR_SELECT_OUT), .mode(OSCILLATOR_GAIN_MODE_OUT), .osc_out(osc));
   initial forever #2.5 REF_CLK = ~REF_CLK;
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge REF_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      AVS_WRITEDATA <= d;
      k = 0;
      do begin
         @(posedge REF_CLK);
         k++;
      end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
      if (k >= 50) chk(1, 0);
      q = AVS_READDATA;
      AVS_READ <= 0;
      AVS_WRITE <= 0;
   endtask
   // cycles until MATCH_OUT is high, bounded
   task wait_match;
      n = 0;
      while (MATCH_OUT !== 1'b1 && n < 400) begin
         @(posedge REF_CLK);
         n++;
      end
   endtask
   task t_resets;
      bus(8'h00, 0, 0); chk(q, 32'h0);
      bus(8'h10, 0, 0); chk(q, 32'hff);
      bus(8'h14, 0, 0); chk(q, 32'h0);
      bus(8'hfc, 1, 32'h8); bus(8'hfc, 0, 0); chk(q, 32'hdeadbeef);
      bus(8'h00, 0, 0); chk(q, 32'h0);
   endtask
   task t_osc;
      for (int m = 0; m < 4; m++) begin
         bus(8'h00, 1, {26'h0, m[1:0], 4'h8});
         repeat (3) @(posedge REF_CLK);
         chk({OSCILLATOR_SELECT_OUT, OSCILLATOR_GAIN_MODE_OUT}, {1'b1, m[1:0]});
      end
   endtask
   // free-running count with export: rate, match, irq, clear
   task t_match_free;
      bus(8'h00, 1, 0); bus(8'h0c, 0, 0); bus(8'h0c, 1, 3); bus(8'h10, 1, 0);
      bus(8'h08, 1, 1); bus(8'h00, 1, 32'h5);
      wait_match;
      chk(n >= 3 * DIV * P - P && n <= 3 * DIV * P + 8, 1);
      chk({SUPPLY_MONITOR_MATCH_OUT, IRQ}, 2'b11);
      bus(8'h14, 0, 0); chk(q, 32'h3);
      repeat (20) @(posedge REF_CLK);
      bus(8'h14, 0, 0); chk(q, 32'h4);
      chk(MATCH_OUT, 0);
      bus(8'h04, 1, 1); repeat (2) @(posedge REF_CLK);
      chk(IRQ, 0);
   endtask
   // loaded start, reset-on-match, no export, irq masked then unmasked
   task t_match_rst;
      bus(8'h00, 1, 0); bus(8'h1c, 1, 2); bus(8'h20, 1, 0); bus(8'h00, 1, 32'h100);
      bus(8'h14, 0, 0); chk(q, 32'h2);
      bus(8'h0c, 0, 0); chk(q, 32'h3);
      bus(8'h0c, 1, 4); bus(8'h08, 1, 0); bus(8'h00, 1, 32'h3);
      wait_match;
      chk({MATCH_OUT, SUPPLY_MONITOR_MATCH_OUT, IRQ}, 3'b100);
      repeat (20) @(posedge REF_CLK);
      bus(8'h14, 0, 0); chk(q, 32'h0);
      bus(8'h08, 1, 1); repeat (2) @(posedge REF_CLK);
      chk(IRQ, 1);
   endtask
   task results;
      if (miscompares == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #(20000 * 5);
      miscompares++;
      results;
   end
   initial begin
      repeat (3) @(posedge REF_CLK);
      SRST <= 0;
      t_resets;
      t_osc;
      t_match_free;
      t_match_rst;
      results;
   end
endmodule // test_rtc_match_counter
